/* logic/mpdc_top.sv */
// position detection, commutation, pwm, angle timer and emergency stop
`timescale 1ns/1ps
`default_nettype none
module mpdc_top #(
  parameter int CNT_W = 4,   // width of match count field
  parameter int BLK_W = 8    // width of blanking and dead-time counts
) (
  input  wire logic             clk_i,                     // 250 MHz system clock
  input  wire logic             rst_n_i,                   // synchronous reset, active low
  input  wire logic             phase_u_sense_i,           // u phase sense
  input  wire logic             phase_v_sense_i,           // v phase sense
  input  wire logic             phase_w_sense_i,           // w phase sense
  input  wire logic             expected_pattern_wr_i,     // store expected pattern
  input  wire logic [2:0]       expected_pattern_i,        // {u,v,w} expected
  input  wire logic             unmatch_mode_i,            // 1: unmatch detection
  input  wire logic [CNT_W-1:0] match_count_field_i,       // consecutive samples
  input  wire logic [BLK_W-1:0] blank_len_i,               // suppress cycles after pwm on
  input  wire logic             sample_start_i,            // start sampling pulse
  input  wire logic             sample_stop_i,             // stop sampling pulse
  input  wire logic             next_mode_wr_i,            // write buffered drive mode
  input  wire logic [2:0]       next_mode_i,               // drive mode 0..5
  input  wire logic             auto_commute_i,            // 1: buffered commutation
  input  wire logic             timer_commute_i,           // timer commutation event
  input  wire logic [11:0]      pwm_period_i,              // pwm period - 1 in 100 ns steps
  input  wire logic [11:0]      pwm_duty_i,                // on time in 100 ns steps
  input  wire logic [BLK_W-1:0] dead_time_i,               // turn-on delay in cycles
  input  wire logic [3:0]       pwm_int_rate_i,            // pwm periods per interrupt - 1
  input  wire logic             angle_run_i,               // angle timer enable
  input  wire logic [8:0]       angle_period_i,            // cycles per degree - 1, 0..383
  input  wire logic             emergency_stop_input_n_i,  // emergency input, active low
  input  wire logic             timer_overflow_i,          // timer overflow event
  input  wire logic [7:0]       emg_key_i,                 // unlock key for emg controls
  input  wire logic             emg_disable_i,             // disable emergency circuit
  input  wire logic             emg_clear_i,               // clear latched stop
  output logic      [5:0]       drive_o,                   // {u,v,w,x,y,z} gate drives
  output logic                  position_detect_interrupt_o, // detection pulse
  output logic                  sampling_o,                // sampling active
  output logic      [2:0]       start_pattern_o,           // inputs at sampling start
  output logic      [2:0]       position_mode_o,           // decoded sensed mode, 7 invalid
  output logic                  pwm_interrupt_o,           // pwm interrupt pulse
  output logic      [8:0]       angle_o,                   // electrical angle 0..359
  output logic                  emg_stopped_o,             // outputs held off
  output logic                  emg_enabled_o              // emergency circuit armed
);
  // elaboration refuses widths that the counters and casts cannot serve
  if (CNT_W < 1 || CNT_W > 8 || BLK_W < 1 || BLK_W > 16) begin : g_bad_param
    $error("mpdc_top: unsupported parameter values");
  end
  // drive pattern {u,v,w,x,y,z} for a commutation mode
  function automatic logic [5:0] drive_pat(input logic [2:0] m);
    case (m)
      3'h0:    drive_pat = 6'b100_010;
      3'h1:    drive_pat = 6'b100_001;
      3'h2:    drive_pat = 6'b010_001;
      3'h3:    drive_pat = 6'b010_100;
      3'h4:    drive_pat = 6'b001_100;
      3'h5:    drive_pat = 6'b001_010;
      default: drive_pat = mpdc_pkg::DRIVE_OFF;
    endcase
  endfunction
  // sensed {u,v,w} to mode index, 7 for the two impossible codes
  function automatic logic [2:0] sense_mode(input logic [2:0] s);
    case (s)
      3'b101:  sense_mode = 3'h0;
      3'b100:  sense_mode = 3'h1;
      3'b110:  sense_mode = 3'h2;
      3'b010:  sense_mode = 3'h3;
      3'b011:  sense_mode = 3'h4;
      3'b001:  sense_mode = 3'h5;
      default: sense_mode = 3'h7;
    endcase
  endfunction
  // raw pin levels as one word, so the delay check can look back at them
  logic [2:0] sense_raw, sense;
  assign sense_raw = {phase_u_sense_i, phase_v_sense_i, phase_w_sense_i};
  mpdc_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (sense_raw),
    .q_o     (sense)
  );
  logic [4:0]       tick_r, tick_nxt;
  logic [11:0]      pwm_cnt_r, pwm_cnt_nxt;
  logic [3:0]       rate_r, rate_nxt;
  logic [BLK_W-1:0] dead_r, dead_nxt;
  logic             raw_on_r, raw_on_nxt;
  logic             pwm_on_r, pwm_on_nxt;
  logic             pwm_int_nxt, step;
  // counter advances one step every 100 ns; dead time delays turn-on only
  always_comb begin
    step        = (tick_r == 5'(mpdc_pkg::PWM_TICK_CYC - 1));
    tick_nxt    = step ? 5'h00 : tick_r + 5'h01;
    pwm_cnt_nxt = pwm_cnt_r;
    rate_nxt    = rate_r;
    pwm_int_nxt = 1'b0;
    if (step) begin
      if (pwm_cnt_r >= pwm_period_i) begin
        pwm_cnt_nxt = 12'h000;
        if (rate_r >= pwm_int_rate_i) begin
          rate_nxt    = 4'h0;
          pwm_int_nxt = 1'b1;
        end else begin
          rate_nxt = rate_r + 4'h1;
        end
      end else begin
        pwm_cnt_nxt = pwm_cnt_r + 12'h001;
      end
    end
    raw_on_nxt = (pwm_cnt_nxt < pwm_duty_i);
    if (raw_on_nxt && !raw_on_r) dead_nxt = dead_time_i;
    else if (dead_r != '0)       dead_nxt = dead_r - 1'b1;
    else                         dead_nxt = dead_r;
    pwm_on_nxt = raw_on_r && (dead_r == '0);
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_r          <= 5'h00;
      pwm_cnt_r       <= 12'h000;
      rate_r          <= 4'h0;
      dead_r          <= '0;
      raw_on_r        <= 1'b0;
      pwm_on_r        <= 1'b0;
      pwm_interrupt_o <= 1'b0;
    end else begin
      tick_r          <= tick_nxt;
      pwm_cnt_r       <= pwm_cnt_nxt;
      rate_r          <= rate_nxt;
      dead_r          <= dead_nxt;
      raw_on_r        <= raw_on_nxt;
      pwm_on_r        <= pwm_on_nxt;
      pwm_interrupt_o <= pwm_int_nxt;
    end
  end
  logic [8:0] pre_r, pre_nxt;
  logic [8:0] angle_nxt;
  // period clamps at 383 so an oversized value cannot stall the angle
  always_comb begin
    pre_nxt   = pre_r;
    angle_nxt = angle_o;
    if (angle_run_i) begin
      if (pre_r >= angle_period_i || pre_r >= mpdc_pkg::ANGLE_PER_MAX) begin
        pre_nxt   = 9'h000;
        angle_nxt = (angle_o >= mpdc_pkg::ANGLE_LAST) ? 9'h000 : angle_o + 9'h001;
      end else begin
        pre_nxt = pre_r + 9'h001;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_r   <= 9'h000;
      angle_o <= 9'h000;
    end else begin
      pre_r   <= pre_nxt;
      angle_o <= angle_nxt;
    end
  end
  mpdc_pkg::mpdc_state_t st_r, st_nxt;
  logic [2:0]       exp_r, exp_nxt;
  logic [2:0]       start_nxt;
  logic [CNT_W-1:0] hit_r, hit_nxt, need;
  logic [BLK_W-1:0] blank_r, blank_nxt;
  logic             hit, det_nxt;
  // a count field of zero is served as one sample
  always_comb begin
    exp_nxt   = expected_pattern_wr_i ? expected_pattern_i : exp_r;
    start_nxt = start_pattern_o;
    st_nxt    = st_r;
    hit_nxt   = hit_r;
    det_nxt   = 1'b0;
    need      = (match_count_field_i == '0) ? CNT_W'(1) : match_count_field_i;
    if (pwm_on_nxt && !pwm_on_r) blank_nxt = blank_len_i;
    else if (blank_r != '0)      blank_nxt = blank_r - 1'b1;
    else                         blank_nxt = blank_r;
    hit = unmatch_mode_i ? (sense != start_pattern_o)
                         : (sense == exp_r);
    case (st_r)
      mpdc_pkg::MPDC_IDLE: begin
        if (sample_start_i) begin
          st_nxt    = mpdc_pkg::MPDC_SAMPLE;
          start_nxt = sense;
          hit_nxt   = '0;
        end
      end
      mpdc_pkg::MPDC_SAMPLE: begin
        if (blank_r != '0) begin
          hit_nxt = hit_r;
        end else if (!hit) begin
          hit_nxt = '0;
        end else if (hit_r + 1'b1 >= need) begin
          det_nxt = 1'b1;
          st_nxt  = mpdc_pkg::MPDC_IDLE;
          hit_nxt = '0;
        end else begin
          hit_nxt = hit_r + 1'b1;
        end
        if (sample_stop_i && !det_nxt) st_nxt = mpdc_pkg::MPDC_IDLE;
      end
      default: st_nxt = mpdc_pkg::MPDC_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r                        <= mpdc_pkg::MPDC_IDLE;
      exp_r                       <= mpdc_pkg::EXPECTED_RST;
      start_pattern_o             <= 3'h0;
      hit_r                       <= '0;
      blank_r                     <= '0;
      position_detect_interrupt_o <= 1'b0;
      sampling_o                  <= 1'b0;
      position_mode_o             <= 3'h7;
    end else begin
      st_r                        <= st_nxt;
      exp_r                       <= exp_nxt;
      start_pattern_o             <= start_nxt;
      hit_r                       <= hit_nxt;
      blank_r                     <= blank_nxt;
      position_detect_interrupt_o <= det_nxt;
      sampling_o                  <= (st_nxt == mpdc_pkg::MPDC_SAMPLE);
      position_mode_o             <= sense_mode(sense);
    end
  end
  logic [2:0] mode_r, mode_nxt, buf_r, buf_nxt;
  logic       emg_en_nxt, emg_stop_nxt, key_ok;
  logic [5:0] drive_nxt;
  // stop wins over clear, and unlocking needs the key so stray writes do nothing
  always_comb begin
    key_ok   = (emg_key_i == mpdc_pkg::EMG_KEY);
    buf_nxt  = (next_mode_wr_i && next_mode_i < 3'(mpdc_pkg::MODE_COUNT)) ? next_mode_i : buf_r;
    mode_nxt = mode_r;
    if (!auto_commute_i) mode_nxt = buf_nxt;
    else if (det_nxt || timer_commute_i) mode_nxt = buf_r;
    emg_en_nxt = (emg_disable_i && key_ok) ? 1'b0 : emg_enabled_o;
    if ((emg_enabled_o && !emergency_stop_input_n_i) || timer_overflow_i)
      emg_stop_nxt = 1'b1;
    else if (emg_clear_i && key_ok)
      emg_stop_nxt = 1'b0;
    else
      emg_stop_nxt = emg_stopped_o;
    drive_nxt = drive_pat(mode_r);
    drive_nxt[5:3] = drive_nxt[5:3] & {3{pwm_on_r}};                     // upper side chopped
    if (emg_stopped_o) drive_nxt = mpdc_pkg::DRIVE_OFF;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_r        <= mpdc_pkg::MODE_RST;
      buf_r         <= mpdc_pkg::MODE_RST;
      emg_enabled_o <= mpdc_pkg::EMG_EN_RST;
      emg_stopped_o <= 1'b0;
      drive_o       <= mpdc_pkg::DRIVE_OFF;
    end else begin
      mode_r        <= mode_nxt;
      buf_r         <= buf_nxt;
      emg_enabled_o <= emg_en_nxt;
      emg_stopped_o <= emg_stop_nxt;
      drive_o       <= drive_nxt;
    end
  end
  // checks, all on the system clock and idle while reset is low
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_emg_trip;
    emg_enabled_o && !emergency_stop_input_n_i;
  endsequence
  sequence s_outputs_off;
    emg_stopped_o ##1 (drive_o == 6'h00);
  endsequence
  chk_drive_mode0: assert property (
    (mode_r == 3'h0 && !emg_stopped_o && pwm_on_r) |=> drive_o == 6'b100_010)
    else $error("mode 0 drive pattern wrong");
  chk_emg_trip_off: assert property (s_emg_trip |=> s_outputs_off)
    else $error("emergency did not stop outputs");
  chk_emg_rst_on: assert property ($rose(rst_n_i) |-> emg_enabled_o)
    else $error("emergency circuit not armed after reset");
  chk_ord_match: assert property ((det_nxt && !unmatch_mode_i) |-> sense == exp_r)
    else $error("ordinary detection without match");
  chk_unm_change: assert property (
    (det_nxt && unmatch_mode_i) |-> sense != start_pattern_o)
    else $error("unmatch detection without change");
  chk_blank_quiet: assert property (blank_r != '0 |-> !det_nxt)
    else $error("detection during blanking");
  chk_count_need: assert property (det_nxt |-> CNT_W'(hit_r + 1'b1) >= need)
    else $error("detection before count reached");
  chk_auto_comm: assert property (
    (auto_commute_i && timer_commute_i) |=> mode_r == $past(buf_r))
    else $error("buffered mode not applied");
  chk_sync_delay: assert property (
    ($past(rst_n_i) && $past(rst_n_i, 2)) |-> sense == $past(sense_raw, 2))
    else $error("synchroniser delay wrong");
  chk_angle_range: assert property (angle_o <= 9'h167)
    else $error("angle beyond 359");
  chk_pwm_step: assert property (!step |=> $stable(pwm_cnt_r))
    else $error("pwm counter moved between steps");
endmodule
`default_nettype wire

/* logic/mpdc_pkg.sv */
// constants shared by the motor position detect and commutation block
// Operation
// - six drive modes select one upper, one lower
// - sense inputs form six-mode position code
// - software writes expected pattern, inputs compared
// - ordinary mode: match raises detect interrupt
// - unmatch mode: change from start value interrupts
// - confirm position after programmable match count
// - suppress detection briefly after pwm turn-on
// - buffered mode applied on detect or timer
// - emergency input or overflow stops outputs, latched
// - emergency circuit enabled after reset
// - 12-bit pwm, 100 ns steps, dead time
// - angle timer counts 360 degrees, period 0-383
// - count field sets consecutive samples before interrupt
`default_nettype none
package mpdc_pkg;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          PWM_RES_NS     = 100;
  localparam int          PWM_TICK_CYC   = (PWM_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PWM_W          = 12;
  localparam int          ANGLE_W        = 9;
  localparam logic [8:0]  ANGLE_LAST     = 9'h0_167;  // 359 degrees
  localparam logic [8:0]  ANGLE_PER_MAX  = 9'h0_17F;  // 383
  localparam int          MODE_COUNT     = 6;
  localparam logic [2:0]  MODE_RST       = 3'h0;
  localparam logic [2:0]  EXPECTED_RST   = 3'h0;
  localparam logic [7:0]  EMG_KEY        = 8'hA5;     // arbitrary unlock value
  localparam logic        EMG_EN_RST     = 1'b1;
  localparam logic [5:0]  DRIVE_OFF      = 6'h00;
  typedef enum logic [0:0] {MPDC_IDLE, MPDC_SAMPLE} mpdc_state_t;
endpackage
`default_nettype wire

/* logic/mpdc_sync.sv */
// two-stage synchroniser for the phase sense inputs
`timescale 1ns/1ps
`default_nettype none
module mpdc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,    // system clock
  input  wire logic         rst_n_i,  // synchronous reset, active low
  input  wire logic [W-1:0] d_i,      // asynchronous levels
  output logic      [W-1:0] q_o       // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end
endmodule
`default_nettype wire

/* verif/mpdc_motor_model.sv */
// behavioural motor model: rotor sense pattern source and bridge watcher
`timescale 1ns/1ps
`default_nettype none
module mpdc_motor_model (
  input  wire logic       clk_i,    // system clock
  input  wire logic [2:0] mode_i,   // rotor mode to present, 0..5
  input  wire logic [5:0] drive_i,  // {u,v,w,x,y,z} gate drives
  output logic            u_o,      // u phase sense level
  output logic            v_o,      // v phase sense level
  output logic            w_o,      // w phase sense level
  output logic            fault_o   // sticky shoot-through flag
);
  logic [2:0] code;
  // rotor mode to {u,v,w} levels; hall outputs always drive, never float
  always_comb begin
    case (mode_i)
      3'h0: code = 3'h5;
      3'h1: code = 3'h4;
      3'h2: code = 3'h6;
      3'h3: code = 3'h2;
      3'h4: code = 3'h3;
      3'h5: code = 3'h1;
      default: code = 3'h0;
    endcase
  end
  // sense pins are plain inputs of the block, never driven back by it
  assign {u_o, v_o, w_o} = code;
  // both switches of one leg on shorts the supply, so it is remembered
  initial fault_o = 1'b0;
  always @(posedge clk_i) begin
    if ((drive_i[5] & drive_i[2]) | (drive_i[4] & drive_i[1]) | (drive_i[3] & drive_i[0])) begin
      fault_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verif/mpdc_top_tb.sv */
// self-checking testbench for the position detect and commutation block
`timescale 1ns/1ps
`default_nettype none
module mpdc_top_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic su, sv, sw, ewr = 1'b0, unm = 1'b0, sstart = 1'b0, sstop = 1'b0;
  logic nwr = 1'b0, autoc = 1'b0, tcom = 1'b0, arun = 1'b0, emg_n = 1'b1;
  logic ovf = 1'b0, edis = 1'b0, eclr = 1'b0;
  logic [2:0] epat = 3'h0, nmode = 3'h0, rotor = 3'h0;
  logic [3:0] cnt = 4'h1, irate = 4'h0;
  logic [7:0] blank = 8'h00, dead = 8'h00, key = 8'h00;
  logic [11:0] per = 12'h000, duty = 12'h001;
  logic [8:0] aper = 9'h000;
  logic [5:0] drv;
  logic pdi, smp, pwmi, stopd, emgen, fault;
  logic [2:0] spat, pmode;
  logic [8:0] ang;
  int num_errors = 0;
  int compares = 0;
  logic [5:0] drive_tab [6] = '{6'h22, 6'h21, 6'h11, 6'h14, 6'h0C, 6'h0A};
  logic [2:0] code_tab [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

  always #2 clk_i = ~clk_i;

  mpdc_motor_model model_u (.clk_i(clk_i), .mode_i(rotor), .drive_i(drv),
    .u_o(su), .v_o(sv), .w_o(sw), .fault_o(fault));

  mpdc_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .phase_u_sense_i(su),
    .phase_v_sense_i(sv), .phase_w_sense_i(sw), .expected_pattern_wr_i(ewr),
    .expected_pattern_i(epat), .unmatch_mode_i(unm), .match_count_field_i(cnt),
    .blank_len_i(blank), .sample_start_i(sstart), .sample_stop_i(sstop),
    .next_mode_wr_i(nwr), .next_mode_i(nmode), .auto_commute_i(autoc),
    .timer_commute_i(tcom), .pwm_period_i(per), .pwm_duty_i(duty), .dead_time_i(dead),
    .pwm_int_rate_i(irate), .angle_run_i(arun), .angle_period_i(aper),
    .emergency_stop_input_n_i(emg_n), .timer_overflow_i(ovf), .emg_key_i(key),
    .emg_disable_i(edis), .emg_clear_i(eclr), .drive_o(drv),
    .position_detect_interrupt_o(pdi), .sampling_o(smp), .start_pattern_o(spat),
    .position_mode_o(pmode), .pwm_interrupt_o(pwmi), .angle_o(ang),
    .emg_stopped_o(stopd), .emg_enabled_o(emgen));

  // every input change lands 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // bounded wait for the detect pulse; a miss ends the run
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && pdi !== 1'b1; i++) tick(1);
    if (pdi !== 1'b1) begin
      num_errors++;
      $display("MISMATCH detect pulse expected 1 seen none");
      print_verdict();
    end
  endtask

  // write one drive mode with auto commutation off and look at the gates
  task automatic set_mode(input logic [2:0] m, input logic [5:0] exp);
    nmode = m;
    nwr = 1'b1;
    tick(1);
    nwr = 1'b0;
    tick(4);
    chk("drive", {3'h0, drv}, {3'h0, exp});
  endtask

  // one ordinary or unmatch run: pattern, count, sampling start and a check that sampling is on
  task automatic arm(input logic [2:0] pat, input logic [3:0] c, input logic um);
    epat = pat;
    cnt = c;
    unm = um;
    ewr = 1'b1;
    tick(1);
    ewr = 1'b0;
    sstart = 1'b1;
    tick(1);
    sstart = 1'b0;
    tick(1);
    chk("sampling", {8'h00, smp}, 9'h001);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      tick(1);
      chk("no detect", {8'h00, pdi}, 9'h000);
    end
  endtask

  initial begin
    int m;
    tick(6);
    chk("drive rst", {3'h0, drv}, 9'h000);
    chk("emg enabled", {8'h00, emgen}, 9'h001);
    chk("mode rst", {6'h00, pmode}, 9'h007);
    chk("angle rst", ang, 9'h000);
    rst_n_i = 1'b1;
    tick(3);
    // sensed code decodes to the mode number, through the synchroniser
    for (m = 0; m < 6; m++) begin
      rotor = 3'(m);
      tick(5);
      chk("sensed mode", {6'h00, pmode}, 9'(m));
    end
    for (m = 5; m >= 0; m--) set_mode(3'(m), drive_tab[m]);
    set_mode(3'h6, drive_tab[0]);
    // trip on the input, clear refused while held or unkeyed
    emg_n = 1'b0;
    tick(3);
    chk("stopped", {8'h00, stopd}, 9'h001);
    chk("drive off", {3'h0, drv}, 9'h000);
    key = 8'hA5;
    eclr = 1'b1;
    tick(1);
    emg_n = 1'b1;
    key = 8'h5A;  // clear strobe stays high, only the key goes wrong
    tick(1);
    eclr = 1'b0;
    tick(2);
    chk("stop held", {8'h00, stopd}, 9'h001);
    key = 8'hA5;
    eclr = 1'b1;
    tick(1);
    eclr = 1'b0;
    tick(3);
    chk("cleared", {8'h00, stopd}, 9'h000);
    chk("drive back", {3'h0, drv}, {3'h0, drive_tab[0]});
    ovf = 1'b1;
    tick(1);
    ovf = 1'b0;
    tick(2);
    chk("ovf stop", {8'h00, stopd}, 9'h001);
    eclr = 1'b1;
    edis = 1'b1;
    tick(1);
    eclr = 1'b0;
    edis = 1'b0;
    emg_n = 1'b0;
    tick(3);
    chk("disabled", {8'h00, emgen}, 9'h000);
    chk("no trip", {8'h00, stopd}, 9'h000);
    emg_n = 1'b1;
    // ordinary match after mismatching samples
    rotor = 3'h0;
    tick(4);
    arm(code_tab[3], 4'h2, 1'b0);
    quiet(4);
    rotor = 3'h3;
    wait_irq(20);
    tick(1);
    chk("pulse width", {8'h00, pdi}, 9'h000);
    chk("sampling done", {8'h00, smp}, 9'h000);
    // two matches then a mismatch must not reach a count of four
    rotor = 3'h0;
    tick(4);
    arm(code_tab[1], 4'h4, 1'b0);
    rotor = 3'h1;
    tick(2);
    rotor = 3'h0;
    quiet(10);
    sstop = 1'b1;
    tick(1);
    sstop = 1'b0;
    tick(1);
    chk("stopped sampling", {8'h00, smp}, 9'h000);
    // unmatch: start value captured, change raises the pulse
    rotor = 3'h2;
    tick(4);
    arm(3'h0, 4'h1, 1'b0);
    sstop = 1'b1;
    tick(1);
    sstop = 1'b0;
    unm = 1'b1;
    sstart = 1'b1;
    tick(1);
    sstart = 1'b0;
    tick(1);
    chk("start pattern", {6'h00, spat}, {6'h00, code_tab[2]});
    quiet(4);
    rotor = 3'h4;
    wait_irq(20);
    unm = 1'b0;
    // buffered commutation waits for the timer event
    autoc = 1'b1;
    nmode = 3'h2;
    nwr = 1'b1;
    tick(1);
    nwr = 1'b0;
    tick(5);
    chk("buffer held", {3'h0, drv}, {3'h0, drive_tab[0]});
    tcom = 1'b1;
    tick(1);
    tcom = 1'b0;
    tick(4);
    chk("buffer applied", {3'h0, drv}, {3'h0, drive_tab[2]});
    autoc = 1'b0;
    // pwm interrupt each period and the angle wrap at 359
    for (m = 0; m < 60 && pwmi !== 1'b1; m++) tick(1);
    chk("pwm irq", {8'h00, pwmi}, 9'h001);
    arun = 1'b1;
    for (m = 0; m < 1000 && ang !== 9'h167; m++) tick(1);
    chk("angle top", ang, 9'h167);
    tick(1);
    chk("angle wrap", ang, 9'h000);
    // chopping pwm with a blank longer than its period hides a standing match
    per = 12'h001;
    duty = 12'h001;
    blank = 8'h3C;
    tick(60);
    arm(code_tab[4], 4'h1, 1'b0);
    quiet(40);
    blank = 8'h00;
    wait_irq(80);
    arun = 1'b0;
    chk("shoot-through", {8'h00, fault}, 9'h000);
    print_verdict();
  end
endmodule
`default_nettype wire
